// file: src/spout_pkg.sv
// Package: register map, field positions, reset values and timing counts
package spout_pkg;
  localparam logic [15:0] OFF_FREQ_CTRL = 16'hff40;
  localparam logic [15:0] OFF_BUZZ_CTRL = 16'hff44;
  localparam logic [15:0] OFF_TIMER_OUT_CTRL = 16'hff30;
  // Timer output register fields
  localparam int TIMER_OUT_EN_BIT = 2;
  localparam int CHANNEL_SEL_BIT = 3;
  // Frequency register fields
  localparam int FREQ_OUT_EN_BIT = 3;
  localparam int FSEL_LSB = 4;
  // Buzzer register fields
  localparam int TONE_ON_BIT = 0;
  localparam int WIDTH_BIT = 4;
  localparam int TRIG_BIT = 5;
  localparam int STOP_BIT = 6;
  localparam logic [2:0] FSEL_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // One-shot widths
  localparam int CLK_HZ = 25_000_000;
  localparam int LONG_US = 125_000;
  localparam int SHORT_US = 31_250;
  localparam int LONG_CYC = CLK_HZ / 1_000_000 * LONG_US;
  localparam int SHORT_CYC = CLK_HZ / 1_000_000 * SHORT_US;
endpackage : spout_pkg

// file: src/special_output_buzzer_control.sv
// Special outputs: timer clock routing, divided oscillator output, buzzer
//
// Summary of operation
// - Timer output clock comes from timer 1 when channel select is 1, else timer 0.
// - Timer clock output enable drives selected clock on pin; else idle level.
// - Three-bit select: low-speed or high-speed oscillator divided by 1, 2, 4, 8.
// - Frequency output enable puts divided clock on pin; otherwise drives high.
// - Writing 1 to trigger starts one burst; read returns busy status.
// - Writing 1 to forced stop ends any burst at once; write-only.
// - Burst lasts 125 ms when width select is 1, 31.25 ms when 0.
// - Buzzer burst switches itself off after the selected width elapses.
// - Buzzer enable outputs signal and inverse; when off, true low, inverse high.
`timescale 1ns/100ps
module special_output_buzzer_control
  import spout_pkg::*;
#(
  parameter int LONG_CYCLES = LONG_CYC,
  parameter int SHORT_CYCLES = SHORT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer0_clk,
  input wire logic timer1_clk,
  input wire logic low_speed_osc_freq,
  input wire logic high_speed_osc_freq,
  input wire logic buzzer_source,
  output logic timer_clock_output,
  output logic divided_osc_output,
  output logic buzzer_signal,
  output logic buzzer_signal_n
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic awready;
    logic wready;
    logic [15:0] awaddr;
    logic [7:0] wdata;
    logic have_aw;
    logic have_w;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [1:0] t0_s;
    logic [1:0] t1_s;
    logic [1:0] lo_s;
    logic [1:0] hi_s;
    logic [1:0] tone_s;
    logic hi_last;
    logic lo_last;
    logic [2:0] div_cnt;
    logic timer_out_channel_select;
    logic timer_clock_out_enable;
    logic freq_out_enable;
    logic [2:0] freq_select;
    logic buzzer_continuous_enable;
    logic buzzer_oneshot_width_select;
    logic busy;
    logic [22:0] shot_cnt;
    logic pin_timer;
    logic pin_divided;
    logic pin_tone;
    logic pin_tone_n;
  } state_t;

  state_t s;
  state_t next_s;
  logic wr_go;
  logic src_edge;
  logic div_bit;
  logic bz_active;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    // Register bus: address and data may arrive in either order
    if (s.awready && s_axi_awvalid) begin
      next_s.awaddr = s_axi_awaddr;
      next_s.have_aw = 1'b1;
      next_s.awready = 1'b0;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.wdata = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      next_s.have_w = 1'b1;
      next_s.wready = 1'b0;
    end
    wr_go = s.have_aw && s.have_w && !s.bvalid;
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end
    // Rising edges only, so each counter bit halves the rate once more
    src_edge = s.freq_select[2] ? (s.hi_s[1] && !s.hi_last) : (s.lo_s[1] && !s.lo_last);
    next_s.hi_last = s.hi_s[1];
    next_s.lo_last = s.lo_s[1];
    next_s.t0_s = {s.t0_s[0], timer0_clk};
    next_s.t1_s = {s.t1_s[0], timer1_clk};
    next_s.lo_s = {s.lo_s[0], low_speed_osc_freq};
    next_s.hi_s = {s.hi_s[0], high_speed_osc_freq};
    next_s.tone_s = {s.tone_s[0], buzzer_source};
    if (src_edge) begin
      next_s.div_cnt = s.div_cnt + 3'h1;
    end
    // One-shot countdown; ends by itself
    if (s.busy) begin
      if (s.shot_cnt <= 23'h00_0001) begin
        next_s.busy = 1'b0;
      end else begin
        next_s.shot_cnt = s.shot_cnt - 23'h00_0001;
      end
    end
    if (wr_go) begin
      next_s.have_aw = 1'b0;
      next_s.have_w = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      case (s.awaddr)
        OFF_TIMER_OUT_CTRL: begin
          next_s.timer_out_channel_select = s.wdata[CHANNEL_SEL_BIT];
          next_s.timer_clock_out_enable = s.wdata[TIMER_OUT_EN_BIT];
        end
        OFF_FREQ_CTRL: begin
          next_s.freq_out_enable = s.wdata[FREQ_OUT_EN_BIT];
          next_s.freq_select = s.wdata[FSEL_LSB+:3];
          next_s.div_cnt = 3'h0;
        end
        OFF_BUZZ_CTRL: begin
          next_s.buzzer_continuous_enable = s.wdata[TONE_ON_BIT];
          next_s.buzzer_oneshot_width_select = s.wdata[WIDTH_BIT];
          // Stop outranks a trigger in the same write
          if (s.wdata[STOP_BIT]) begin
            next_s.busy = 1'b0;
          end else if (s.wdata[TRIG_BIT]) begin
            next_s.busy = 1'b1;
            next_s.shot_cnt = s.wdata[WIDTH_BIT] ? 23'(LONG_CYCLES)
                                                  : 23'(SHORT_CYCLES);
          end
        end
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end
    // Read channel
    if (s.arready && s_axi_arvalid) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      case (s_axi_araddr)
        OFF_TIMER_OUT_CTRL: next_s.rdata = {4'h0, s.timer_out_channel_select,
                                       s.timer_clock_out_enable, 2'h0};
        OFF_FREQ_CTRL: next_s.rdata = {1'b0, s.freq_select, s.freq_out_enable, 3'h0};
        OFF_BUZZ_CTRL: next_s.rdata = {2'h0, s.busy, s.buzzer_oneshot_width_select,
                                       3'h0, s.buzzer_continuous_enable};
        default: begin
          next_s.rdata = 8'h00;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
    // Output pins
    next_s.pin_timer = s.timer_clock_out_enable &&
      (s.timer_out_channel_select ? s.t1_s[1] : s.t0_s[1]);
    case (s.freq_select[1:0])
      2'h0: div_bit = s.freq_select[2] ? s.hi_s[1] : s.lo_s[1];
      2'h1: div_bit = s.div_cnt[0];
      2'h2: div_bit = s.div_cnt[1];
      default: div_bit = s.div_cnt[2];
    endcase
    next_s.pin_divided = s.freq_out_enable ? div_bit : 1'b1;
    bz_active = s.buzzer_continuous_enable || s.busy;
    next_s.pin_tone = bz_active && s.tone_s[1];
    next_s.pin_tone_n = !(bz_active && s.tone_s[1]);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.freq_select <= FSEL_RESET;
      s.pin_divided <= 1'b1;
      s.pin_tone_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = {24'h00_0000, s.rdata};
  assign timer_clock_output = s.pin_timer;
  assign divided_osc_output = s.pin_divided;
  assign buzzer_signal = s.pin_tone;
  assign buzzer_signal_n = s.pin_tone_n;

  ////////////////////////////////////////////////////////////////////////////
  chk_timer_channel_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    s.timer_clock_out_enable && $stable(s.timer_clock_out_enable) |->
    timer_clock_output == $past(s.timer_out_channel_select ? s.t1_s[1] : s.t0_s[1]))
    else $error("timer clock from wrong channel");
  chk_timer_idle_low: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(s.timer_clock_out_enable) |-> !timer_clock_output)
    else $error("timer clock pin not idle");
  chk_freq_idle_high: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(s.freq_out_enable) |-> divided_osc_output)
    else $error("frequency pin not high");
  chk_fsel_direct: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(s.freq_out_enable) && $past(s.freq_select) == 3'h0 |->
    divided_osc_output == $past(s.lo_s[1]))
    else $error("undivided low-speed clock wrong");
  chk_trig_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && s.awaddr == OFF_BUZZ_CTRL && s.wdata[TRIG_BIT] && !s.wdata[STOP_BIT] |=>
    s.busy [*8])
    else $error("trigger did not start burst");
  chk_stop_now: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && s.awaddr == OFF_BUZZ_CTRL && s.wdata[STOP_BIT] |=> !s.busy)
    else $error("forced stop ignored");
  chk_width_load: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s.busy) |-> s.shot_cnt == (s.buzzer_oneshot_width_select ?
      23'(LONG_CYCLES) : 23'(SHORT_CYCLES)))
    else $error("burst length wrong");
  chk_auto_off: assert property (@(posedge aclk) disable iff (!aresetn)
    s.busy && s.shot_cnt == 23'h00_0001 && !wr_go |=> !s.busy)
    else $error("burst did not end");
  chk_tone_off_levels: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(s.buzzer_continuous_enable) && !$past(s.busy) |->
    !buzzer_signal && buzzer_signal_n)
    else $error("buzzer idle levels wrong");
endmodule : special_output_buzzer_control

// file: tb/spout_pins_model.sv
// Pin-side model: timer, oscillator and buzzer tone sources
`timescale 1ns/100ps
module spout_pins_model (
  input wire logic aclk,
  output logic timer0_clk,
  output logic timer1_clk,
  output logic low_speed_osc_freq,
  output logic high_speed_osc_freq,
  output logic buzzer_source
);
  logic [4:0] tick = 5'h00;
  always @(posedge aclk) begin
    tick <= tick + 5'h01;
  end
  // Every level lasts 2+ cycles, so the synchronisers never miss one
  assign timer0_clk = tick[3];
  assign timer1_clk = tick[2];
  assign low_speed_osc_freq = tick[4];
  assign high_speed_osc_freq = tick[1];
  assign buzzer_source = tick[2];
endmodule : spout_pins_model

// file: tb/special_output_buzzer_control_tb_top.sv
// Testbench: registers, pin routing and one-shot buzzer
`timescale 1ns/100ps
module special_output_buzzer_control_tb_top
  import spout_pkg::*;
;
  localparam int LONG_N = 400;
  localparam int SHORT_N = 100;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid, t0, t1, lo, hi, tone;
  logic pin_tmr, pin_div, pin_tone, pin_tone_n;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] mon;
  int err_count = 0, compares = 0, cycles = 0;
  int c[9];
  assign mon = {tone, pin_tone, pin_tmr, pin_div, t1, t0, hi, lo};
  special_output_buzzer_control #(.LONG_CYCLES(LONG_N), .SHORT_CYCLES(SHORT_N)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer0_clk(t0), .timer1_clk(t1), .low_speed_osc_freq(lo), .high_speed_osc_freq(hi),
    .buzzer_source(tone), .timer_clock_output(pin_tmr), .divided_osc_output(pin_div),
    .buzzer_signal(pin_tone), .buzzer_signal_n(pin_tone_n));
  spout_pins_model u_pins (.aclk(aclk), .timer0_clk(t0), .timer1_clk(t1),
    .low_speed_osc_freq(lo), .high_speed_osc_freq(hi), .buzzer_source(tone));
  initial begin
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    // Tests need about 7k cycles
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rs = bresp;
  endtask : wr
  task automatic rd_reg(input logic [15:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask : rd_reg
  // Toggle counts tolerate the sync lag at both window ends
  task automatic tog(input int n);
    logic [7:0] p;
    c = '{default: 0};
    p = mon;
    repeat (n) begin
      @(posedge aclk);
      for (int i = 0; i < 8; i++) c[i] += int'(mon[i] !== p[i]);
      c[8] += int'(pin_tone_n !== ~pin_tone);
      p = mon;
    end
  endtask : tog
  function automatic logic near(input int o, input int s, input int d);
    return (o * d <= s + d) && (o * d + d >= s);
  endfunction : near
  ////////////////////////////////////////
  task automatic test_reset();
    @(posedge aclk);
    check("idle timer", pin_tmr, 1'b0);
    check("idle freq", pin_div, 1'b1);
    check("idle tone", {pin_tone, pin_tone_n}, 2'b01);
    rd_reg(OFF_TIMER_OUT_CTRL);
    check("timer reset", rd, 32'h0000_0000);
    check("read resp", rs, RESP_OKAY);
    rd_reg(OFF_FREQ_CTRL);
    check("freq reset", rd, 32'h0000_0000);
    rd_reg(OFF_BUZZ_CTRL);
    check("buzz reset", rd, 32'h0000_0000);
    rd_reg(16'h0000);
    check("unmapped read", rs, RESP_SLVERR);
    wr(16'h0000, 8'hff);
    check("unmapped write", rs, RESP_SLVERR);
    $display("reset test done");
  endtask : test_reset
  // Settle after each write so the old setting stays out of the count
  task automatic test_timer();
    for (int ch = 0; ch < 2; ch++) begin
      wr(OFF_TIMER_OUT_CTRL, 8'((1 << TIMER_OUT_EN_BIT) | (ch << CHANNEL_SEL_BIT)));
      check("write resp", rs, RESP_OKAY);
      repeat (8) @(posedge aclk);
      tog(512);
      check("timer routing", near(c[5], ch ? c[3] : c[2], 1), 1'b1);
    end
    wr(OFF_TIMER_OUT_CTRL, 8'h00);
    repeat (8) @(posedge aclk);
    tog(256);
    check("timer off", {c[5] == 0, pin_tmr}, 2'b10);
    $display("timer test done");
  endtask : test_timer
  task automatic test_freq();
    for (int k = 0; k < 8; k++) begin
      wr(OFF_FREQ_CTRL, 8'((k << FSEL_LSB) | (1 << FREQ_OUT_EN_BIT)));
      repeat (16) @(posedge aclk);
      tog(512);
      check("freq divide", near(c[4], k[2] ? c[1] : c[0], 1 << k[1:0]), 1'b1);
    end
    wr(OFF_FREQ_CTRL, 8'h70);
    repeat (8) @(posedge aclk);
    tog(256);
    check("freq off", {c[4] == 0, pin_div}, 2'b11);
    $display("freq test done");
  endtask : test_freq
  task automatic test_tone();
    wr(OFF_BUZZ_CTRL, 8'h01);
    repeat (8) @(posedge aclk);
    tog(256);
    check("tone on", {near(c[6], c[7], 1), c[8] == 0}, 2'b11);
    wr(OFF_BUZZ_CTRL, 8'h00);
    repeat (8) @(posedge aclk);
    tog(128);
    check("tone off", {c[6] == 0, pin_tone, pin_tone_n}, 3'b101);
    $display("tone test done");
  endtask : test_tone
  task automatic test_oneshot();
    for (int w = 0; w < 2; w++) begin
      wr(OFF_BUZZ_CTRL, 8'((1 << TRIG_BIT) | (w << WIDTH_BIT)));
      rd_reg(OFF_BUZZ_CTRL);
      check("busy", rd, 32'((1 << TRIG_BIT) | (w << WIDTH_BIT)));
      tog((w ? LONG_N : SHORT_N) - 40);
      rd_reg(OFF_BUZZ_CTRL);
      check("still busy", {c[6] > 0, rd[TRIG_BIT]}, 2'b11);
      repeat (60) @(posedge aclk);
      rd_reg(OFF_BUZZ_CTRL);
      check("ready", rd, 32'(w << WIDTH_BIT));
      check("quiet", {pin_tone, pin_tone_n}, 2'b01);
    end
    $display("one-shot test done");
  endtask : test_oneshot
  task automatic test_stop();
    wr(OFF_BUZZ_CTRL, 8'((1 << TRIG_BIT) | (1 << WIDTH_BIT)));
    repeat (20) @(posedge aclk);
    wr(OFF_BUZZ_CTRL, 8'((1 << STOP_BIT) | (1 << WIDTH_BIT)));
    rd_reg(OFF_BUZZ_CTRL);
    repeat (4) @(posedge aclk);
    check("stopped", rd, 32'(1 << WIDTH_BIT));
    check("stop quiet", {pin_tone, pin_tone_n}, 2'b01);
    $display("stop test done");
  endtask : test_stop
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset();
    test_timer();
    test_freq();
    test_tone();
    test_oneshot();
    test_stop();
    test_done();
  end
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
endmodule : special_output_buzzer_control_tb_top
